// file: hw/islk_pkg.sv
// Constants and types for the two-wire slave link layer
package islk_pkg;

  // ----------------------------------------------------------------------
  // Addresses and byte codes
  // ----------------------------------------------------------------------
  localparam logic [6:0] ISLK_ADDR_OPT0   = 7'h40;
  localparam logic [6:0] ISLK_ADDR_OPT1   = 7'h48;
  localparam logic [6:0] ISLK_ADDR_OPT2   = 7'h44;
  localparam logic [6:0] ISLK_ADDR_OPT3   = 7'h4c;
  localparam logic [6:0] ISLK_ADDR_TEST   = 7'h49;
  localparam logic [7:0] ISLK_GCALL_BYTE  = 8'h00;
  localparam logic [4:0] ISLK_HS_CODE_HI  = 5'h01;

  // ----------------------------------------------------------------------
  // Framing and timing
  // ----------------------------------------------------------------------
  localparam int         ISLK_BYTE_BITS   = 8;
  localparam logic [2:0] ISLK_BIT_LAST    = 3'h7;
  localparam int         ISLK_SYS_MHZ     = 200;
  localparam int         ISLK_SPIKE_FS_NS = 50;
  localparam int         ISLK_SPIKE_HS_NS = 10;
  localparam int         ISLK_FILT_FS_CYC = (ISLK_SPIKE_FS_NS * ISLK_SYS_MHZ) / 1000 < 1 ?
                                            1 : (ISLK_SPIKE_FS_NS * ISLK_SYS_MHZ) / 1000;
  localparam int         ISLK_FILT_HS_CYC = (ISLK_SPIKE_HS_NS * ISLK_SYS_MHZ) / 1000 < 1 ?
                                            1 : (ISLK_SPIKE_HS_NS * ISLK_SYS_MHZ) / 1000;
  localparam int         ISLK_FIFO_DEPTH  = 16;
  localparam logic [1:0] ISLK_LINES_IDLE  = 2'h3;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [7:0] {
    ISLK_IDLE     = 8'h01,
    ISLK_ADDR     = 8'h02,
    ISLK_ADDR_ACK = 8'h04,
    ISLK_WRITE    = 8'h08,
    ISLK_WR_ACK   = 8'h10,
    ISLK_READ     = 8'h20,
    ISLK_RD_ACK   = 8'h40,
    ISLK_IGNORE   = 8'h80
  } islk_state_t;

  typedef struct packed {
    logic       first;
    logic [7:0] data;
  } islk_rx_word_t;

  typedef struct packed {
    logic scl;
    logic sda;
  } islk_bus_t;

endpackage : islk_pkg

// file: hw/islk_line_filter.sv
// Synchroniser and spike filter for both bus lines
`timescale 1ns/1ps
`default_nettype none
module islk_line_filter #(
  parameter logic [7:0] LEN_FS = 8'h0a,
  parameter logic [7:0] LEN_HS = 8'h02
) (
  // Clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              reset_i,
  // Lines
  input  wire islk_pkg::islk_bus_t line_i,
  input  wire logic              hs_i,
  output var  islk_pkg::islk_bus_t line_o
);
  import islk_pkg::*;

  typedef struct packed {
    logic [1:0]      meta;
    logic [1:0]      sync;
    logic [1:0]      filt;
    logic [1:0][7:0] cnt;
  } islk_filt_st_t;

  islk_filt_st_t q, d;
  logic [7:0]    len;

  always_comb begin
    d   = q;
    len = hs_i ? LEN_HS : LEN_FS;
    d.meta = {line_i.scl, line_i.sda};
    d.sync = q.meta;
    // New level must hold len cycles; shorter spikes vanish
    for (int i = 0; i < 2; i++) begin
      if (q.sync[i] == q.filt[i]) begin
        d.cnt[i] = 8'h00;
      end else if (q.cnt[i] + 8'h01 >= len) begin
        d.filt[i] = q.sync[i];
        d.cnt[i]  = 8'h00;
      end else begin
        d.cnt[i] = q.cnt[i] + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '{meta: ISLK_LINES_IDLE, sync: ISLK_LINES_IDLE, filt: ISLK_LINES_IDLE, cnt: '0};
    end else begin
      q <= d;
    end
  end

  assign line_o = '{scl: q.filt[1], sda: q.filt[0]};

endmodule : islk_line_filter
`default_nettype wire

// file: hw/islk_fifo.sv
// Receive FIFO with registered head word
`timescale 1ns/1ps
`default_nettype none
module islk_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_sys_i,
  input  wire logic             reset_i,
  // Fill side
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             in_ready_o,
  // Drain side
  output var  logic             out_valid_o,
  output var  logic [WIDTH-1:0] out_data_o,
  input  wire logic             out_ready_i
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wptr;
    logic [PW-1:0]               rptr;
    logic [PW:0]                 count;
    logic [WIDTH-1:0]            out_q;
    logic                        out_vld;
  } islk_fifo_st_t;

  islk_fifo_st_t q, d;
  logic          push;
  logic          load;

  always_comb begin
    d          = q;
    in_ready_o = (q.count != PW'(0) + (PW+1)'(DEPTH));
    push       = in_valid_i && in_ready_o;
    load       = (q.count != '0) && (!q.out_vld || out_ready_i);
    if (push) begin
      d.mem[q.wptr] = in_data_i;
      d.wptr        = q.wptr + PW'(1);
    end
    if (load) begin
      d.out_q   = q.mem[q.rptr];
      d.out_vld = 1'b1;
      d.rptr    = q.rptr + PW'(1);
    end else if (out_ready_i) begin
      d.out_vld = 1'b0;
    end
    d.count = q.count + (PW+1)'(push) - (PW+1)'(load);
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign out_valid_o = q.out_vld;
  assign out_data_o  = q.out_q;

endmodule : islk_fifo
`default_nettype wire

// file: hw/islk_link_layer.sv
// Two-wire bus slave link layer: framing, addressing, acknowledge and speed mode
`timescale 1ns/1ps
`default_nettype none
module islk_link_layer #(
  parameter int FILT_FS_CYC = islk_pkg::ISLK_FILT_FS_CYC,
  parameter int FILT_HS_CYC = islk_pkg::ISLK_FILT_HS_CYC,
  parameter int FIFO_DEPTH  = islk_pkg::ISLK_FIFO_DEPTH
) (
  // Clock and reset
  input  wire logic                    clk_sys_i,
  input  wire logic                    reset_i,
  // Bus pins (data is open drain, clock is input only)
  input  wire logic                    scl_i,
  input  wire logic                    sda_i,
  output var  logic                    sda_o,
  output var  logic                    sda_oe_o,
  // Straps
  input  wire logic [1:0]              addr_opt_i,
  input  wire logic                    test_unlock_i,
  // Received bytes
  output var  logic                    rx_valid_o,
  output var  islk_pkg::islk_rx_word_t rx_data_o,
  input  wire logic                    rx_ready_i,
  // Bytes to send
  input  wire logic [7:0]              tx_data_i,
  output var  logic                    tx_req_o,
  // Status
  output var  logic                    busy_o,
  output var  logic                    hs_mode_o,
  output var  logic                    start_o,
  output var  logic                    stop_o
);
  import islk_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    islk_state_t   state;
    logic [2:0]    cnt;
    logic [7:0]    shreg;
    logic [7:0]    txsh;
    logic          byte_done;
    logic          rw;
    logic          mack;
    logic          first;
    logic          hs;
    logic          busy;
    logic          sda_oe;
    logic          tx_req;
    logic          start_p;
    logic          stop_p;
    logic          push;
    islk_rx_word_t push_word;
    islk_bus_t     prev;
    logic [1:0]    opt_m;
    logic [1:0]    opt_s;
    logic          unl_m;
    logic          unl_s;
  } islk_st_t;

  islk_st_t  q, d;
  islk_bus_t pins;
  islk_bus_t filt;
  logic      fifo_ready;
  logic      scl_rise;
  logic      scl_fall;
  logic      start_cond;
  logic      stop_cond;

  // ----------------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------------
  function automatic logic [6:0] main_addr(input logic [1:0] opt);
    case (opt)
      2'h0:    main_addr = ISLK_ADDR_OPT0;
      2'h1:    main_addr = ISLK_ADDR_OPT1;
      2'h2:    main_addr = ISLK_ADDR_OPT2;
      default: main_addr = ISLK_ADDR_OPT3;
    endcase
  endfunction : main_addr

  function automatic logic addr_hit(input logic [7:0] b, input logic [1:0] opt,
                                    input logic unl);
    // Direction bit takes no part in the compare
    addr_hit = (b[7:1] == main_addr(opt))
            || (unl && (b[7:1] == ISLK_ADDR_TEST));
  endfunction : addr_hit

  // ----------------------------------------------------------------------
  // Line conditioning
  // ----------------------------------------------------------------------
  assign pins = '{scl: scl_i, sda: sda_i};

  islk_line_filter #(
    .LEN_FS (8'(FILT_FS_CYC)),
    .LEN_HS (8'(FILT_HS_CYC))
  ) u_filter (
    .clk_sys_i (clk_sys_i),
    .reset_i   (reset_i),
    .line_i    (pins),
    .hs_i      (q.hs),
    .line_o    (filt)
  );

  // Edges and conditions come only from filtered samples
  assign scl_rise   = filt.scl && !q.prev.scl;
  assign scl_fall   = !filt.scl && q.prev.scl;
  assign start_cond = filt.scl && q.prev.scl && q.prev.sda && !filt.sda;
  assign stop_cond  = filt.scl && q.prev.scl && !q.prev.sda && filt.sda;

  // ----------------------------------------------------------------------
  // Receive FIFO
  // ----------------------------------------------------------------------
  islk_fifo #(
    .WIDTH ($bits(islk_rx_word_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_sys_i   (clk_sys_i),
    .reset_i     (reset_i),
    .in_valid_i  (q.push),
    .in_data_i   (q.push_word),
    .in_ready_o  (fifo_ready),
    .out_valid_o (rx_valid_o),
    .out_data_o  (rx_data_o),
    .out_ready_i (rx_ready_i)
  );

  // ----------------------------------------------------------------------
  // Protocol engine
  // ----------------------------------------------------------------------
  always_comb begin
    d         = q;
    d.start_p = 1'b0;
    d.stop_p  = 1'b0;
    d.tx_req  = 1'b0;
    d.push    = 1'b0;
    d.prev    = filt;
    d.opt_m   = addr_opt_i;
    d.opt_s   = q.opt_m;
    d.unl_m   = test_unlock_i;
    d.unl_s   = q.unl_m;

    if (stop_cond) begin
      d.state  = ISLK_IDLE;
      d.sda_oe = 1'b0;
      d.busy   = 1'b0;
      d.hs     = 1'b0;
      d.stop_p = 1'b1;
    end else if (start_cond) begin
      // Repeated start takes this same path; speed mode is kept
      d.state     = ISLK_ADDR;
      d.cnt       = 3'h0;
      d.byte_done = 1'b0;
      d.sda_oe    = 1'b0;
      d.busy      = 1'b1;
      d.start_p   = 1'b1;
    end else begin
      case (q.state)
        ISLK_IDLE: begin
          d.sda_oe = 1'b0;
        end

        ISLK_ADDR, ISLK_WRITE: begin
          if (scl_rise) begin
            // Sample once per period, MSB first
            d.shreg = {q.shreg[6:0], filt.sda};
            d.cnt   = q.cnt + 3'h1;
            if (q.cnt == ISLK_BIT_LAST) begin
              d.byte_done = 1'b1;
            end
          end else if (scl_fall && q.byte_done) begin
            d.byte_done = 1'b0;
            d.cnt       = 3'h0;
            if (q.state == ISLK_ADDR) begin
              if (!q.hs && (q.shreg[7:3] == ISLK_HS_CODE_HI)) begin
                // Master code: leave the slot released, shorten filters
                d.hs     = 1'b1;
                d.state  = ISLK_IGNORE;
              end else if (q.shreg == ISLK_GCALL_BYTE) begin
                d.state  = ISLK_IGNORE;
              end else if (addr_hit(q.shreg, q.opt_s, q.unl_s)) begin
                d.rw     = q.shreg[0];
                d.sda_oe = 1'b1;
                d.state  = ISLK_ADDR_ACK;
                d.tx_req = q.shreg[0];
              end else begin
                // Covers device-id and every foreign address
                d.state  = ISLK_IGNORE;
              end
            end else begin
              // No clock stretching exists, so a full FIFO can only refuse
              d.sda_oe         = fifo_ready;
              d.push           = fifo_ready;
              d.push_word.first = q.first;
              d.push_word.data  = q.shreg;
              d.first          = 1'b0;
              d.state          = ISLK_WR_ACK;
            end
          end
        end

        ISLK_ADDR_ACK: begin
          if (scl_fall) begin
            d.cnt = 3'h0;
            if (q.rw) begin
              d.txsh   = tx_data_i;
              d.sda_oe = !tx_data_i[7];
              d.state  = ISLK_READ;
            end else begin
              d.sda_oe = 1'b0;
              d.first  = 1'b1;
              d.state  = ISLK_WRITE;
            end
          end
        end

        ISLK_WR_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.state  = ISLK_WRITE;
          end
        end

        ISLK_READ: begin
          if (scl_fall) begin
            if (q.cnt == ISLK_BIT_LAST) begin
              d.sda_oe = 1'b0;
              d.state  = ISLK_RD_ACK;
            end else begin
              // Change data only while the clock is low
              d.txsh   = {q.txsh[6:0], 1'b0};
              d.sda_oe = !q.txsh[6];
              d.cnt    = q.cnt + 3'h1;
            end
          end
        end

        ISLK_RD_ACK: begin
          if (scl_rise) begin
            d.mack   = !filt.sda;
            d.tx_req = !filt.sda;
          end else if (scl_fall) begin
            d.cnt = 3'h0;
            if (q.mack) begin
              d.txsh   = tx_data_i;
              d.sda_oe = !tx_data_i[7];
              d.state  = ISLK_READ;
            end else begin
              // Master refused: wait for its stop or repeated start
              d.sda_oe = 1'b0;
              d.state  = ISLK_IGNORE;
            end
          end
        end

        ISLK_IGNORE: begin
          d.sda_oe = 1'b0;
        end

        default: begin
          d.state  = ISLK_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      q       <= '0;
      q.state <= ISLK_IDLE;
      q.prev  <= '{scl: 1'b1, sda: 1'b1};
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  // Pin only ever pulls low; no clock driver exists at all
  assign sda_o     = 1'b0;
  assign sda_oe_o  = q.sda_oe;
  assign tx_req_o  = q.tx_req;
  assign busy_o    = q.busy;
  assign hs_mode_o = q.hs;
  assign start_o   = q.start_p;
  assign stop_o    = q.stop_p;

endmodule : islk_link_layer
`default_nettype wire

// file: verif/islk_link_layer_sva.sv
// Port checker for the two-wire slave link layer
`timescale 1ns/1ps
`default_nettype none
module islk_link_layer_sva
  import islk_pkg::*;
(
  // Clock and reset
  input wire logic                    clk_sys_i,
  input wire logic                    reset_i,
  // Bus
  input wire logic                    scl_i,
  input wire logic                    sda_i,
  input wire logic                    sda_o,
  input wire logic                    sda_oe_o,
  // Stream and status
  input wire logic                    rx_valid_o,
  input wire islk_pkg::islk_rx_word_t rx_data_o,
  input wire logic                    rx_ready_i,
  input wire logic                    busy_o,
  input wire logic                    hs_mode_o,
  input wire logic                    start_o,
  input wire logic                    stop_o
);
  // ----------
  // Checks
  // ----------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);

  a_drive_low_only: assert property (sda_o == 1'b0)
    else $error("data output value not low");
  a_idle_release: assert property (!busy_o |-> !sda_oe_o)
    else $error("data line pulled while idle");
  // Two samples of slack cover the filter delay after the clock rises
  a_scl_high_stable: assert property (scl_i && $past(scl_i) && $past(scl_i, 2)
    |-> $stable(sda_oe_o)) else $error("data changed while clock high");
  a_ack_held: assert property ($rose(scl_i) && sda_oe_o |=> sda_oe_o [*4])
    else $error("low level not held through clock high");
  a_start_seen: assert property ($fell(sda_i) && scl_i |-> ##[1:20] start_o)
    else $error("start not reported");
  a_stop_seen: assert property ($rose(sda_i) && scl_i |-> ##[1:20] stop_o)
    else $error("stop not reported");
  a_start_busy: assert property (start_o |-> ##[0:2] busy_o)
    else $error("busy missing after start");
  a_stop_idle: assert property (stop_o |-> ##[0:2] (!busy_o && !hs_mode_o))
    else $error("stop left busy or fast filters");
  a_busy_ends: assert property ($fell(busy_o) |-> stop_o)
    else $error("frame ended without a stop");
  a_start_single: assert property (start_o |=> !start_o)
    else $error("start reported twice in a row");
  a_hs_in_frame: assert property ($rose(hs_mode_o) |-> busy_o)
    else $error("fast filters outside a frame");
  a_rx_hold: assert property (rx_valid_o && !rx_ready_i
    |=> rx_valid_o && $stable(rx_data_o)) else $error("head word lost");
endmodule : islk_link_layer_sva
`default_nettype wire

// file: verif/islk_bus_master.sv
// Behavioural two-wire bus master for the bench
`timescale 1ns/1ps
`default_nettype none
module islk_bus_master (
  // Lines, open drain: 1 releases
  output var  logic scl_o,
  output var  logic sda_o,
  input  wire logic sda_i
);
  // Quarter of the 64 ns bus period
  localparam int QTR = 16;

  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Start and repeated start look alike on the wire
  task automatic start();
    sda_o = 1'b1;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b0;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask : start

  task automatic stop();
    sda_o = 1'b0;
    #QTR scl_o = 1'b1;
    #QTR sda_o = 1'b1;
    #(2 * QTR);
  endtask : stop

  // Data set in the low phase, sampled mid high
  task automatic bit_xfer(input logic b, output logic r);
    sda_o = b;
    #QTR scl_o = 1'b1;
    #QTR r = sda_i;
    #QTR scl_o = 1'b0;
    #QTR;
  endtask : bit_xfer

  // Ack handed back so the caller can check it
  task automatic wr_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_xfer(b[i], r);
    bit_xfer(1'b1, r);
    ack = !r;
  endtask : wr_byte

  task automatic rd_byte(input logic mack, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_xfer(1'b1, r);
      b[i] = r;
    end
    bit_xfer(!mack, r);
  endtask : rd_byte
endmodule : islk_bus_master
`default_nettype wire

// file: verif/islk_link_layer_test.sv
// Self-checking bench for the two-wire slave link layer
`timescale 1ns/1ps
`default_nettype none
module islk_link_layer_test;
  import islk_pkg::*;
  // ----------
  // Signals
  // ----------
  logic          clk_sys_i = 1'b0;
  logic          reset_i   = 1'b1;
  logic          scl, sda_rel, sda_o, sda_oe_o;
  logic [1:0]    addr_opt  = 2'h0;
  logic          unlock    = 1'b0;
  logic          rx_ready  = 1'b1;
  logic [7:0]    tx_data   = 8'h94;
  logic          rx_valid, tx_req, busy, hs, start_p, stop_p;
  islk_rx_word_t rx_data;
  logic [8:0]    rxq[$];
  int            err_count = 0;
  int            n_tests   = 0;
  int            cyc       = 0;
  // Pull-up wins unless a party pulls low
  wire logic     sda_w     = sda_rel & ~sda_oe_o;

  islk_bus_master m (.scl_o(scl), .sda_o(sda_rel), .sda_i(sda_w));
  // Filter of one cycle keeps both phases of the 64 ns bus clock long enough
  islk_link_layer #(.FILT_FS_CYC(1), .FILT_HS_CYC(1), .FIFO_DEPTH(16)) dut (
    .clk_sys_i, .reset_i, .scl_i(scl), .sda_i(sda_w), .sda_o, .sda_oe_o,
    .addr_opt_i(addr_opt), .test_unlock_i(unlock), .rx_valid_o(rx_valid),
    .rx_data_o(rx_data), .rx_ready_i(rx_ready), .tx_data_i(tx_data),
    .tx_req_o(tx_req), .busy_o(busy), .hs_mode_o(hs), .start_o(start_p),
    .stop_o(stop_p));

  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (rx_valid && rx_ready) rxq.push_back(rx_data);
    if (cyc == 20000) begin
      err_count++;
      $display("MISMATCH %0t run did not finish", $time);
      print_verdict();
    end
  end
  // Next read byte offered on each request
  always @(negedge clk_sys_i) if (tx_req) tx_data <= tx_data + 8'h11;

  // ----------
  // Helpers
  // ----------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [8:0] got, input logic [8:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check

  task automatic settle();
    repeat (12) @(negedge clk_sys_i);
  endtask : settle

  task automatic send(input logic [7:0] b, input logic exp_ack, input string what);
    logic a;
    m.wr_byte(b, a);
    check(9'(a), 9'(exp_ack), what);
  endtask : send

  task automatic pop_rx(input logic [8:0] exp);
    logic [8:0] w;
    w = 'x;
    if (rxq.size() != 0) w = rxq.pop_front();
    check(w, exp, "received word");
  endtask : pop_rx

  // ----------
  // Scenarios
  // ----------
  task automatic t_options();
    logic [6:0] opt [4];
    opt = '{ISLK_ADDR_OPT0, ISLK_ADDR_OPT1, ISLK_ADDR_OPT2, ISLK_ADDR_OPT3};
    for (int o = 0; o < 4; o++) begin
      @(negedge clk_sys_i) addr_opt = 2'(o);
      settle();
      m.start();
      send({opt[o], 1'b0}, 1'b1, "main address");
      send(8'hff, 1'b1, "top pointer");
      send(8'h5a, 1'b1, "data byte");
      m.stop();
      settle();
      pop_rx({1'b1, 8'hff});
      pop_rx({1'b0, 8'h5a});
      check(9'(busy), 9'h0, "busy after stop");
    end
  endtask : t_options

  task automatic t_reject();
    logic [7:0] bad [5];
    bad = '{8'h92, ISLK_GCALL_BYTE, 8'hf8, 8'h82, 8'h90};
    @(negedge clk_sys_i) addr_opt = 2'h0;
    settle();
    for (int i = 0; i < 5; i++) begin
      m.start();
      send(bad[i], 1'b0, "foreign address");
      send(8'h00, 1'b0, "byte while ignored");
      m.stop();
      settle();
    end
    @(negedge clk_sys_i) unlock = 1'b1;
    settle();
    m.start();
    send({ISLK_ADDR_TEST, 1'b0}, 1'b1, "unlocked test address");
    m.stop();
    @(negedge clk_sys_i) unlock = 1'b0;
    settle();
    check(9'(rxq.size()), 9'h0, "nothing received");
  endtask : t_reject

  task automatic t_read();
    logic [7:0] b;
    m.start();
    send(8'h80, 1'b1, "write address");
    send(8'h10, 1'b1, "pointer");
    m.start();
    send(8'h81, 1'b1, "read address");
    m.rd_byte(1'b1, b);
    check(9'(b), 9'ha5, "first read byte");
    m.rd_byte(1'b0, b);
    check(9'(b), 9'hb6, "last read byte");
    m.stop();
    settle();
    pop_rx({1'b1, 8'h10});
  endtask : t_read

  task automatic t_hs();
    m.start();
    send(8'h0b, 1'b0, "master code");
    settle(); // Clock stands still mid frame
    check(9'(hs), 9'h1, "fast filters on");
    m.start();
    settle();
    check(9'(hs), 9'h1, "kept over repeated start");
    send(8'h80, 1'b1, "fast address");
    send(8'h33, 1'b1, "fast data");
    m.stop();
    settle();
    check(9'(hs), 9'h0, "filters back after stop");
    pop_rx({1'b1, 8'h33});
  endtask : t_hs

  task automatic t_fifo();
    @(negedge clk_sys_i) rx_ready = 1'b0;
    m.start();
    send(8'h80, 1'b1, "write address");
    // Sixteen stored plus the head word, then refusal
    for (int i = 0; i < 18; i++) send(8'(i), i < 17, "byte into buffer");
    m.stop();
    @(negedge clk_sys_i) rx_ready = 1'b1;
    repeat (40) @(negedge clk_sys_i);
    for (int i = 0; i < 17; i++) pop_rx({i == 0, 8'(i)});
    check(9'(rxq.size()), 9'h0, "buffer drained");
  endtask : t_fifo

  initial begin
    repeat (20) @(negedge clk_sys_i);
    reset_i = 1'b0;
    settle();
    t_options();
    t_reject();
    t_read();
    t_hs();
    t_fifo();
    print_verdict();
  end
endmodule : islk_link_layer_test

bind islk_link_layer islk_link_layer_sva u_sva (.clk_sys_i, .reset_i, .scl_i, .sda_i,
  .sda_o, .sda_oe_o, .rx_valid_o, .rx_data_o, .rx_ready_i, .busy_o, .hs_mode_o,
  .start_o, .stop_o);
`default_nettype wire
